// File: core/add_and_shift_left_alu.sv
/*
  Execution block for add, 16-bit add, AND and shift left, with its own
  instruction fetch on the processor memory bus and an Avalon-MM slave
  for the programmer-visible registers. Assumes memory answers read data
  within the same cycle on the sys_clk domain, and that software only
  starts an instruction while the block is idle.
*/
// Notes on behaviour
// - Add sums the chosen accumulator and memory byte without carry in and stores it back.
// - 8-bit add sets half-carry on a carry out of bit 3, clears it otherwise.
// - 8-bit results give negative from bit 7 and zero when all eight bits are clear.
// - Overflow is set when both operands share a sign and the result sign differs.
// - Carry is set when a carry leaves the top bit of the sum.
// - Add to A decodes as 9B direct and AB indexed, to B as DB and EB, 18 prefixes Y.
// - 16-bit add uses M as high and M+1 as low byte, opcodes C3, D3, E3, F3, H kept.
// - The double accumulator is A above B.
// - 16-bit results give negative from bit 15 and zero when all sixteen bits clear.
// - AND replaces the accumulator with the bitwise AND, sets N and Z, clears V.
// - AND to A decodes as 84, 94, B4, A4 and to B as C4, D4, F4, E4.
// - Shift left moves bits up, loads zero at bit 0, keeps half-carry.
// - Shift left puts the old top bit into carry.
// - After a shift, overflow is negative XOR carry.
// - Shift opcodes are 48, 58, 68 and 78; memory forms end with a write cycle.
`timescale 1ns/1ps
`include "alu_cfg.svh"
module add_and_shift_left_alu
  import alu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [15:0] busAddr,
  output logic busRw,
  output logic [7:0] busWdata,
  input wire logic [7:0] busRdata,
  output logic instrDone
);

  // ==========================================
  // State
  seq_state_t state_q, state_d;
  logic [7:0] accA_q, accA_d;
  logic [7:0] accB_q, accB_d;
  logic [7:0] ccr_q, ccr_d;
  logic [15:0] ix_q, ix_d;
  logic [15:0] iy_q, iy_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] opc_q, opc_d;
  logic pfxY_q, pfxY_d;
  logic [7:0] arg_q, arg_d;
  logic [15:0] ea_q, ea_d;
  logic [15:0] opd_q, opd_d;
  logic [15:0] busAddr_q, busAddr_d;
  logic busRw_q, busRw_d;
  logic [7:0] busWdata_q, busWdata_d;
  logic illegal_q, illegal_d;
  logic done_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic exec;

  // ==========================================
  // Avalon slave handshake
  // Every access waits exactly one enabled cycle, so read data can come from a
  // flop and writes land at the single edge where waitrequest is low.
  wire logic req = avs_read | avs_write;
  wire logic busy = (state_q != S_IDLE);
  wire logic swWr = avs_write & ack_q & ~busy;
  wire logic selA = (avs_address == `OFS_ACC_A);
  wire logic selB = (avs_address == `OFS_ACC_B);
  wire logic selC = (avs_address == `OFS_CCR);
  wire logic selX = (avs_address == `OFS_IX);
  wire logic selY = (avs_address == `OFS_IY);
  wire logic selP = (avs_address == `OFS_PC);
  wire logic selK = (avs_address == `OFS_CTRL);
  wire logic selS = (avs_address == `OFS_STAT);
  wire logic startGo = swWr & selK & avs_byteenable[0] & avs_writedata[`CTRL_START];

  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata = rdata_q;

  // Read selection; unmapped offsets read as zero.
  wire logic [7:0] statByte = {6'h00, illegal_q, busy};
  wire logic [31:0] rdMux =
    selA ? {24'h000000, accA_q} :
    selB ? {24'h000000, accB_q} :
    selC ? {24'h000000, ccr_q} :
    selX ? {16'h0000, ix_q} :
    selY ? {16'h0000, iy_q} :
    selP ? {16'h0000, pc_q} :
    selS ? {24'h000000, statByte} : 32'h00000000;

  // Byte-lane merge for the 16-bit registers.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ==========================================
  // Opcode decode
  // The byte being fetched is decoded in the opcode cycle itself, later
  // cycles decode the latched copy, so a single decoder serves both.
  wire logic [7:0] decByte = (state_q == S_OPC) ? busRdata : opc_q;
  wire logic [3:0] loNib = decByte[3:0];
  wire logic isAdd8 = decByte[7] & (loNib == `LO_ADD8);
  wire logic isAnd8 = decByte[7] & (loNib == `LO_AND8);
  wire logic isAdd16 = (decByte[7:6] == 2'b11) & (loNib == `LO_ADD16);
  wire logic isAsl = (decByte[7:6] == 2'b01) & (loNib == `LO_ASL);
  wire logic isPfx = (decByte == `OPC_PFX_Y) & ~pfxY_q;

  // Mode: bits 5:4 give immediate, direct, indexed or extended; the
  // shift uses 4x and 5x for the accumulators.
  wire addr_mode_t modeStd = (decByte[5:4] == 2'b00) ? AM_IMM :
                             (decByte[5:4] == 2'b01) ? AM_DIR :
                             (decByte[5:4] == 2'b10) ? AM_IDX : AM_EXT;
  wire addr_mode_t modeAsl = ~decByte[5] ? AM_INH :
                             decByte[4] ? AM_EXT : AM_IDX;
  wire addr_mode_t mode = isAsl ? modeAsl : modeStd;

  // Only indexed forms may carry the Y prefix.
  wire logic known = isAdd8 | isAnd8 | isAdd16 | isAsl;
  wire logic legal = known & (~pfxY_q | (mode == AM_IDX));
  wire logic accSelB = isAsl ? decByte[4] : decByte[6];
  wire logic aslMem = isAsl & (mode != AM_INH);
  wire alu_op_t aluOp = isAdd16 ? OP_ADD16 :
                        isAnd8 ? OP_AND8 :
                        isAsl ? OP_ASL8 : OP_ADD8;

  // ==========================================
  // Datapath helpers
  wire logic [15:0] double_accumulator = {accA_q, accB_q};
  wire logic [15:0] selected_accumulator = accSelB ? {8'h00, accB_q} : {8'h00, accA_q};
  wire logic [15:0] aluX = isAdd16 ? double_accumulator : aslMem ? opd_q : selected_accumulator;
  wire logic [15:0] aluM = (state_q == S_DEAD) ? opd_q : {8'h00, busRdata};
  wire logic [15:0] pcInc = pc_q + 16'h0001;
  wire logic [15:0] eaNext = ea_q + 16'h0001;
  logic [15:0] eaNow;
  logic [15:0] aluRes;
  logic [7:0] aluCcr;

  alu_ea_gen u_ea (
    .mode(mode),
    .useY(pfxY_q),
    .argHi(arg_q),
    .byteIn(busRdata),
    .ix(ix_q),
    .iy(iy_q),
    .ea(eaNow)
  );

  alu_flag_core u_core (
    .op(aluOp),
    .x(aluX),
    .m(aluM),
    .ccrIn(ccr_q),
    .res(aluRes),
    .ccrOut(aluCcr)
  );

  // ==========================================
  // Bus cycle sequencer
  // Each state is one bus cycle; the address for the next cycle is
  // computed here and registered, and read data is taken at the edge
  // that ends the cycle.
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    opc_d = opc_q;
    pfxY_d = pfxY_q;
    arg_d = arg_q;
    ea_d = ea_q;
    opd_d = opd_q;
    illegal_d = illegal_q;
    busAddr_d = `IDLE_ADDR;
    busRw_d = 1'b1;
    busWdata_d = busWdata_q;
    exec = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        if (startGo) begin
          state_d = S_OPC;
          busAddr_d = pc_q;
          pfxY_d = 1'b0;
          illegal_d = 1'b0;
        end
      end
      S_OPC: begin
        pc_d = pcInc;
        opc_d = busRdata;
        busAddr_d = pcInc;
        if (isPfx) begin
          pfxY_d = 1'b1;
        end else if (!legal) begin
          illegal_d = 1'b1;
          state_d = S_IDLE;
          busAddr_d = `IDLE_ADDR;
        end else if (mode == AM_INH) begin
          state_d = S_INH;
        end else begin
          state_d = S_ARG1;
        end
      end
      S_ARG1: begin
        pc_d = pcInc;
        arg_d = busRdata;
        unique case (mode)
          AM_IMM: begin
            if (isAdd16) begin
              state_d = S_ARG2;
              busAddr_d = pcInc;
            end else begin
              exec = 1'b1;
              state_d = S_IDLE;
            end
          end
          AM_DIR: begin
            ea_d = eaNow;
            state_d = S_MEM1;
            busAddr_d = eaNow;
          end
          AM_EXT: begin
            state_d = S_ARG2;
            busAddr_d = pcInc;
          end
          AM_IDX: begin
            ea_d = eaNow;
            state_d = S_IDX;
          end
          AM_INH: begin
            state_d = S_IDLE;
          end
        endcase
      end
      S_ARG2: begin
        pc_d = pcInc;
        if (mode == AM_IMM) begin
          opd_d = {arg_q, busRdata};
          state_d = S_DEAD;
        end else begin
          ea_d = eaNow;
          state_d = S_MEM1;
          busAddr_d = eaNow;
        end
      end
      S_IDX: begin
        state_d = S_MEM1;
        busAddr_d = ea_q;
      end
      S_MEM1: begin
        if (isAdd16) begin
          opd_d[15:8] = busRdata;
          state_d = S_MEM2;
          busAddr_d = eaNext;
        end else if (aslMem) begin
          opd_d = {8'h00, busRdata};
          state_d = S_DEAD;
        end else begin
          exec = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_MEM2: begin
        opd_d[7:0] = busRdata;
        state_d = S_DEAD;
      end
      S_DEAD: begin
        exec = 1'b1;
        if (aslMem) begin
          state_d = S_WRITE;
          busAddr_d = ea_q;
          busRw_d = 1'b0;
          busWdata_d = aluRes[7:0];
        end else begin
          state_d = S_IDLE;
        end
      end
      S_INH: begin
        exec = 1'b1;
        state_d = S_IDLE;
      end
      S_WRITE: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // ==========================================
  // Programmer registers: software writes when idle, results when busy
  // Software writes are refused while an instruction runs, which keeps
  // the two writers of each register apart without arbitration.
  always_comb begin
    accA_d = accA_q;
    accB_d = accB_q;
    ccr_d = ccr_q;
    ix_d = ix_q;
    iy_d = iy_q;
    if (swWr && selA && avs_byteenable[0]) accA_d = avs_writedata[7:0];
    if (swWr && selB && avs_byteenable[0]) accB_d = avs_writedata[7:0];
    if (swWr && selC && avs_byteenable[0]) ccr_d = avs_writedata[7:0];
    if (swWr && selX) ix_d = merge16(ix_q, avs_writedata, avs_byteenable);
    if (swWr && selY) iy_d = merge16(iy_q, avs_writedata, avs_byteenable);
    if (exec) begin
      ccr_d = aluCcr;
      if (isAdd16) begin
        {accA_d, accB_d} = aluRes;
      end else if (aslMem) begin
        ccr_d = aluCcr;
      end else if (accSelB) begin
        accB_d = aluRes[7:0];
      end else begin
        accA_d = aluRes[7:0];
      end
    end
  end

  // Program counter load by software shares the sequencer's next value.
  wire logic [15:0] pcNext = (swWr && selP) ?
    merge16(pc_q, avs_writedata, avs_byteenable) : pc_d;

  // ==========================================
  // Flops
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else if (clkEn) begin
      ack_q <= req & ~ack_q;
      if (avs_read && !ack_q) rdata_q <= rdMux;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      accA_q <= 8'h00;
      accB_q <= 8'h00;
      ccr_q <= `RST_CCR;
      ix_q <= 16'h0000;
      iy_q <= 16'h0000;
      pc_q <= `RST_PC;
    end else if (clkEn) begin
      accA_q <= accA_d;
      accB_q <= accB_d;
      ccr_q <= ccr_d;
      ix_q <= ix_d;
      iy_q <= iy_d;
      pc_q <= pcNext;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      opc_q <= 8'h00;
      pfxY_q <= 1'b0;
      arg_q <= 8'h00;
      ea_q <= 16'h0000;
      opd_q <= 16'h0000;
      illegal_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clkEn) begin
      state_q <= state_d;
      opc_q <= opc_d;
      pfxY_q <= pfxY_d;
      arg_q <= arg_d;
      ea_q <= ea_d;
      opd_q <= opd_d;
      illegal_q <= illegal_d;
      done_q <= (state_d == S_IDLE) && (state_q != S_IDLE);
    end
  end

  // Bus outputs come straight from flops; idle cycles read at FFFF.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      busAddr_q <= `IDLE_ADDR;
      busRw_q <= 1'b1;
      busWdata_q <= 8'h00;
    end else if (clkEn) begin
      busAddr_q <= busAddr_d;
      busRw_q <= busRw_d;
      busWdata_q <= busWdata_d;
    end
  end

  assign busAddr = busAddr_q;
  assign busRw = busRw_q;
  assign busWdata = busWdata_q;
  assign instrDone = done_q;

endmodule

// File: core/alu_cfg.svh
/*
  Offsets, field positions, opcodes and reset values for the add, AND
  and shift-left execution block. Assumes inclusion by bare name.
*/
`ifndef ALU_CFG_SVH
`define ALU_CFG_SVH

// ==========================================
// Register byte offsets on the Avalon slave
`define OFS_ACC_A 5'h00
`define OFS_ACC_B 5'h04
`define OFS_CCR 5'h08
`define OFS_IX 5'h0c
`define OFS_IY 5'h10
`define OFS_PC 5'h14
`define OFS_CTRL 5'h18
`define OFS_STAT 5'h1c

// ==========================================
// Condition code bit positions
`define CCR_H 5
`define CCR_N 3
`define CCR_Z 2
`define CCR_V 1
`define CCR_C 0

// ==========================================
// Control and status bit positions
`define CTRL_START 0
`define STAT_BUSY 0
`define STAT_ILLEGAL 1

// ==========================================
// Opcode fields
`define OPC_PFX_Y 8'h18
`define LO_ADD8 4'hb
`define LO_AND8 4'h4
`define LO_ADD16 4'h3
`define LO_ASL 4'h8

// ==========================================
// Reset values and idle bus address
`define RST_CCR 8'h00
`define RST_PC 16'h0000
`define IDLE_ADDR 16'hffff

`endif

// File: core/alu_pkg.sv
/*
  Types shared by the execution block and its helpers.
  Assumes nothing of its surroundings.
*/
package alu_pkg;

  // ==========================================
  // Operation, addressing mode and sequencer state
  typedef enum logic [1:0] {OP_ADD8, OP_AND8, OP_ASL8, OP_ADD16} alu_op_t;
  typedef enum logic [2:0] {AM_IMM, AM_DIR, AM_IDX, AM_EXT, AM_INH} addr_mode_t;
  typedef enum logic [3:0] {
    S_IDLE, S_OPC, S_ARG1, S_ARG2, S_IDX, S_MEM1, S_MEM2, S_DEAD, S_INH, S_WRITE
  } seq_state_t;

endpackage

// File: core/alu_ea_gen.sv
/*
  Effective address from the addressing mode, the operand bytes and the
  index registers. Purely combinational; the caller registers it.
*/
`timescale 1ns/1ps
`include "alu_cfg.svh"
module alu_ea_gen
  import alu_pkg::*;
(
  input addr_mode_t mode,
  input wire logic useY,
  input wire logic [7:0] argHi,
  input wire logic [7:0] byteIn,
  input wire logic [15:0] ix,
  input wire logic [15:0] iy,
  output logic [15:0] ea
);

  // ==========================================
  // Address forming
  // The indexed offset is unsigned, so it is zero-extended before adding.
  wire logic [15:0] base = useY ? iy : ix;
  wire logic [15:0] idxSum = base + {8'h00, byteIn};

  assign ea = (mode == AM_DIR) ? {8'h00, byteIn} :
              (mode == AM_EXT) ? {argHi, byteIn} :
              (mode == AM_IDX) ? idxSum : `IDLE_ADDR;

endmodule

// File: core/alu_flag_core.sv
/*
  Result and condition codes for 8-bit add, AND, shift left and 16-bit add.
  Combinational; assumes the caller commits result and flags together.
*/
`timescale 1ns/1ps
`include "alu_cfg.svh"
module alu_flag_core
  import alu_pkg::*;
(
  input alu_op_t op,
  input wire logic [15:0] x,
  input wire logic [15:0] m,
  input wire logic [7:0] ccrIn,
  output logic [15:0] res,
  output logic [7:0] ccrOut
);

  // ==========================================
  // Arithmetic
  // Incoming carry is never added: these are add-without-carry forms.
  wire logic [8:0] sum8 = {1'b0, x[7:0]} + {1'b0, m[7:0]};
  wire logic [16:0] sum16 = {1'b0, x} + {1'b0, m};
  wire logic [4:0] nib = {1'b0, x[3:0]} + {1'b0, m[3:0]};
  wire logic [7:0] and8 = x[7:0] & m[7:0];
  wire logic [7:0] asl8 = {x[6:0], 1'b0};

  // Per-operation result and flags.
  always_comb begin
    res = 16'h0000;
    ccrOut = ccrIn;
    unique case (op)
      OP_ADD8: begin
        res = {8'h00, sum8[7:0]};
        ccrOut[`CCR_H] = nib[4];
        ccrOut[`CCR_V] = (x[7] == m[7]) && (sum8[7] != x[7]);
        ccrOut[`CCR_C] = sum8[8];
      end
      OP_AND8: begin
        res = {8'h00, and8};
        ccrOut[`CCR_V] = 1'b0;
      end
      OP_ASL8: begin
        res = {8'h00, asl8};
        ccrOut[`CCR_C] = x[7];
        ccrOut[`CCR_V] = asl8[7] ^ x[7];
      end
      OP_ADD16: begin
        res = sum16[15:0];
        ccrOut[`CCR_V] = (x[15] == m[15]) && (sum16[15] != x[15]);
        ccrOut[`CCR_C] = sum16[16];
      end
    endcase
    // Sign and zero follow the width of the operation.
    if (op == OP_ADD16) begin
      ccrOut[`CCR_N] = res[15];
      ccrOut[`CCR_Z] = (res == 16'h0000);
    end else begin
      ccrOut[`CCR_N] = res[7];
      ccrOut[`CCR_Z] = (res[7:0] == 8'h00);
    end
  end

endmodule

// File: test/alu_monitor.sv
/*
  Port checks for the add, AND and shift-left block.
  Assumes one sys_clk domain with synchronous active-low rst_b.
*/
`timescale 1ns/1ps
module alu_monitor (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [15:0] busAddr,
  input wire logic busRw,
  input wire logic instrDone
);
  // ==========================================
  // Sequences
  // A request counts only on an edge that the enable lets through.
  sequence avs_taken;
    (avs_read || avs_write) && avs_waitrequest && clkEn;
  endsequence
  // Operand read, idle cycle, then the write of a read-modify-write.
  sequence rmw_tail;
    (busRw && clkEn) ##1 (busRw && clkEn) ##1 $fell(busRw);
  endsequence

  // ==========================================
  // Assertions
  wait_one_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    avs_taken |=> !avs_waitrequest) else $error("Avalon wait longer than one cycle.");
  wait_first_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(avs_read || avs_write) |-> avs_waitrequest) else $error("Avalon answered at once.");
  hold_rdata_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !avs_read |=> $stable(avs_readdata)) else $error("Read data moved without a read.");
  done_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    instrDone |-> busAddr == 16'hffff && busRw) else $error("Bus not idle at done.");
  done_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    instrDone && clkEn |=> !instrDone) else $error("Done pulse too long.");
  reset_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(rst_b) && $past(clkEn) |-> busAddr == 16'hffff && busRw && !instrDone
      && avs_readdata == 32'h0) else $error("Outputs not idle after reset.");
  write_last_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !busRw && clkEn |=> busRw && busAddr == 16'hffff) else $error("Write not last cycle.");
  rmw_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rmw_tail |-> busAddr == $past(busAddr, 2) && $past(busAddr) == 16'hffff)
    else $error("Write address differs from operand read.");
endmodule

bind add_and_shift_left_alu alu_monitor i_alu_monitor (.sys_clk(sys_clk), .rst_b(rst_b),
  .clkEn(clkEn), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .busAddr(busAddr), .busRw(busRw), .instrDone(instrDone));

// File: test/alu_mem_model.sv
/*
  Byte memory on the processor bus: read in the same cycle, written at
  the edge that ends a write cycle. Assumes registered bus outputs.
*/
`timescale 1ns/1ps
module alu_mem_model (
  input wire logic sys_clk,
  input wire logic clkEn,
  input wire logic [15:0] busAddr,
  input wire logic busRw,
  input wire logic [7:0] busWdata,
  output logic [7:0] busRdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] noiseQ = 8'h00;
  // ==========================================
  // Storage
  // A pattern fill keeps idle and prefetch reads from returning unknowns.
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h3c ^ i[7:0];
  end
  // Writes land only on enabled edges, as the block's own flops move.
  always @(posedge sys_clk) begin
    noiseQ <= noiseQ + 8'h5b;
    if (clkEn && !busRw) mem[busAddr] <= busWdata;
  end
  // During a write the lines are not ours, so they carry changing noise.
  assign busRdata = busRw ? mem[busAddr] : noiseQ;
endmodule

// File: test/add_and_shift_left_alu_tb.sv
/*
  Self-checking bench: random registers and operands over Avalon, a
  memory model on the bus, and a reference model of results and flags.
  Assumes the design files and the memory model compile first.
*/
`timescale 1ns/1ps
`include "alu_cfg.svh"
module add_and_shift_left_alu_tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clkEn = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] busAddr;
  logic busRw;
  logic [7:0] busWdata;
  logic [7:0] busRdata;
  logic instrDone;
  logic [31:0] rngState = 32'd57;
  logic [31:0] expRd [$];
  logic [23:0] expWr [$];
  int error_cnt = 0;
  int total_checks = 0;
  logic [7:0] opcs [24] = '{8'h8b, 8'h9b, 8'hab, 8'hbb, 8'hcb, 8'hdb, 8'heb, 8'hfb,
    8'h84, 8'h94, 8'ha4, 8'hb4, 8'hc4, 8'hd4, 8'he4, 8'hf4,
    8'hc3, 8'hd3, 8'he3, 8'hf3, 8'h48, 8'h58, 8'h68, 8'h78};

  add_and_shift_left_alu i_add_and_shift_left_alu (.sys_clk(sys_clk), .rst_b(rst_b),
    .clkEn(clkEn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busAddr(busAddr),
    .busRw(busRw), .busWdata(busWdata), .busRdata(busRdata), .instrDone(instrDone));
  alu_mem_model i_alu_mem_model (.sys_clk(sys_clk), .clkEn(clkEn), .busAddr(busAddr),
    .busRw(busRw), .busWdata(busWdata), .busRdata(busRdata));

  // ==========================================
  // Clock, random source and reference model
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] rnd();
    rngState = rngState ^ (rngState << 13);
    rngState = rngState ^ (rngState >> 17);
    rngState = rngState ^ (rngState << 5);
    return rngState;
  endfunction
  // Kind 0 add, 1 AND, 2 shift left, 3 16-bit add; returns result then flags.
  function automatic logic [23:0] model(input logic [1:0] k, input logic [15:0] x,
      input logic [15:0] m, input logic [7:0] c);
    logic [16:0] s;
    logic [4:0] h;
    logic [7:0] f;
    f = c;
    h = {1'b0, x[3:0]} + {1'b0, m[3:0]};
    s = (k == 2'd3) ? {1'b0, x} + {1'b0, m} : (k == 2'd1) ? {9'h0, x[7:0] & m[7:0]} :
      (k == 2'd2) ? {8'h0, x[7:0], 1'b0} : {9'h0, x[7:0]} + {9'h0, m[7:0]};
    if (k == 2'd0) f[5] = h[4];
    if (k == 2'd3) begin
      f[3] = s[15];
      f[2] = (s[15:0] == 16'h0);
      f[1] = (x[15] == m[15]) && (s[15] != x[15]);
      f[0] = s[16];
    end else begin
      f[3] = s[7];
      f[2] = (s[7:0] == 8'h0);
      f[1] = (k == 2'd1) ? 1'b0 : (k == 2'd2) ? s[7] ^ x[7] : (x[7] == m[7]) && (s[7] != x[7]);
      if (k != 2'd1) f[0] = (k == 2'd2) ? x[7] : s[8];
    end
    return {s[15:0], f};
  endfunction

  // ==========================================
  // Avalon master and result watchers
  // Raise after an edge, hold until waitrequest is seen low, release after that edge.
  task automatic avs(input logic wr, input logic [4:0] a, input logic [31:0] d,
      input logic [31:0] e);
    @(posedge sys_clk);
    if (!wr) expRd.push_back(e);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    // Waitrequest is taken at the rising edge; only the watchdog ends a wait.
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    avs(1'b1, a, d, 32'h0);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    avs(1'b0, a, 32'h0, e);
  endtask
  task automatic chkRd(input logic [4:0] a, input logic [31:0] got);
    logic [31:0] e;
    e = 32'hx;
    if (expRd.size() > 0) e = expRd.pop_front();
    total_checks++;
    if (got !== e) begin
      error_cnt++;
      $display("[ERR] register %h expected %h seen %h", a, e, got);
    end
  endtask
  task automatic chkWr(input logic [23:0] got);
    logic [23:0] e;
    e = 24'hx;
    if (expWr.size() > 0) e = expWr.pop_front();
    total_checks++;
    if (got !== e) begin
      error_cnt++;
      $display("[ERR] bus write expected %h seen %h", e, got);
    end
  endtask
  // Outputs are looked at mid-cycle, where they have settled.
  always @(negedge sys_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      chkRd(avs_address, avs_readdata);
    if (rst_b === 1'b1 && clkEn === 1'b1 && busRw === 1'b0)
      chkWr({busAddr, busWdata});
  end

  // ==========================================
  // One instruction with random state; stall makes the clock enable random.
  task automatic exec(input logic [7:0] opc, input logic useY, input logic stall);
    logic [31:0] v, w, s;
    logic [1:0] k, md;
    logic [15:0] pc, p, ea, len;
    logic [23:0] r;
    logic memAsl, useB, ill;
    v = rnd();
    w = rnd();
    k = (opc[3:0] == 4'hb) ? 2'd0 : (opc[3:0] == 4'h4) ? 2'd1 : (opc[3:0] == 4'h8) ? 2'd2 : 2'd3;
    md = opc[5:4];
    memAsl = (k == 2'd2) && md[1];
    useB = (k == 2'd2) ? (md == 2'd1) : opc[6];
    ill = (opc == 8'h83) || (useY && (md != 2'd2));
    pc = {8'h10, w[31:24]};
    p = pc + {15'h0, useY};
    ea = (md == 2'd0) ? p + 16'h1 : (md == 2'd1) ? {8'h00, w[15:8]} : (md == 2'd3) ?
      {1'b1, w[22:16], w[15:8]} : {useY ? 8'h60 : 8'h40, w[23:16]} + {8'h0, w[15:8]};
    len = (k == 2'd2 && !md[1]) ? 16'h1 : (md == 2'd3) ? 16'h3 : (k == 2'd3 && md == 2'd0) ?
      16'h3 : 16'h2;
    i_alu_mem_model.mem[pc] = 8'h18;
    i_alu_mem_model.mem[p] = opc;
    i_alu_mem_model.mem[p + 16'h1] = (md == 2'd3) ? {1'b1, w[22:16]} : w[15:8];
    i_alu_mem_model.mem[p + 16'h2] = w[15:8];
    i_alu_mem_model.mem[ea] = v[31:24];
    i_alu_mem_model.mem[ea + 16'h1] = w[7:0];
    r = model(k, (k == 2'd3) ? {v[7:0], v[15:8]} : {8'h0, memAsl ? v[31:24] : useB ?
      v[15:8] : v[7:0]}, {(k == 2'd3) ? v[31:24] : 8'h0, (k == 2'd3) ? w[7:0] : v[31:24]},
      v[23:16]);
    wr(`OFS_ACC_A, {24'h0, v[7:0]});
    wr(`OFS_ACC_B, {24'h0, v[15:8]});
    wr(`OFS_CCR, {24'h0, v[23:16]});
    wr(`OFS_IX, {16'h0, 8'h40, w[23:16]});
    wr(`OFS_IY, {16'h0, 8'h60, w[23:16]});
    wr(`OFS_PC, {16'h0, pc});
    if (memAsl && !ill) expWr.push_back({ea, r[15:8]});
    wr(`OFS_CTRL, 32'h1);
    do begin
      @(posedge sys_clk);
      s = rnd();
      clkEn <= stall ? (s[0] | s[1]) : 1'b1;
      @(negedge sys_clk);
    end while (instrDone !== 1'b1);
    @(posedge sys_clk);
    clkEn <= 1'b1;
    rd(`OFS_ACC_A, {24'h0, (ill || memAsl || (k != 2'd3 && useB)) ? v[7:0] : (k == 2'd3) ?
      r[23:16] : r[15:8]});
    rd(`OFS_ACC_B, {24'h0, (ill || memAsl || (k != 2'd3 && !useB)) ? v[15:8] :
      r[15:8]});
    rd(`OFS_CCR, {24'h0, ill ? v[23:16] : r[7:0]});
    if (!ill) rd(`OFS_PC, {16'h0, p + len});
    rd(`OFS_STAT, ill ? 32'h2 : 32'h0);
    $display("test opcode %h prefix %b finished", opc, useY);
  endtask

  task automatic end_of_test();
    if (expRd.size() + expWr.size() > 0) error_cnt++;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(`OFS_CCR, 32'h0);
    rd(`OFS_PC, 32'h0);
    rd(`OFS_STAT, 32'h0);
    rd(5'h06, 32'h0);
    $display("test reset values finished");
    for (int pass = 0; pass < 2; pass++) begin
      foreach (opcs[i]) begin
        exec(opcs[i], 1'b0, pass[0]);
        if (opcs[i][5:4] == 2'h2) exec(opcs[i], 1'b1, pass[0]);
      end
    end
    exec(8'h83, 1'b0, 1'b0);
    exec(8'h8b, 1'b1, 1'b0);
    exec(8'h84, 1'b0, 1'b0);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(`OFS_ACC_A, 32'h0);
    rd(`OFS_CCR, 32'h0);
    $display("test second reset finished");
    end_of_test();
  end
  // Sixty-three instructions of some fifty cycles each fit well inside this span.
  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    end_of_test();
  end
endmodule
